/* File: hw/ptwb_pkg.sv */
// Purpose: constants, field layout and types of the pixel tone and white balance stage
// Assumes: 12-bit pixels, 32-bit AXI4-Lite register words
// Notes: pixel maths is fixed at 12 bits per colour
//
// Summary of operation
// - gamma enabled applies one of eight curves
// - gamma 1.3..2.2 compresses darks, expands brights
// - gamma 1/1.3..1/2.2 expands darks, compresses brights
// - black gamma, eight settings, dark half only
// - black gamma weighted 10, 20 or 30 percent
// - four loadable tables, one preset gamma 0.45
// - table select plus enable overriding base gamma
// - tables reset to gamma, invert, 2x, identity
// - enhancement off passes pixels unchanged
// - one-point mode uses a single knee
// - two-point mode uses two knees
// - separate red, green, blue gains multiply pixels
// - white balance off leaves colours uncorrected
// - one-shot measures once, then holds coefficients
// - auto measures every frame, applies next frame
// - manual applies host coefficients 0 to 4095
// - auto tracking speed 1x slowest, 5x fastest
// - indoor 3200 and outdoor 5600 preset gains
// - applied coefficients readable by host anytime
package ptwb_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_MAN_RG = 8'h04;
	localparam logic [7:0] OFF_MAN_B  = 8'h08;
	localparam logic [7:0] OFF_KNEE1  = 8'h0c;
	localparam logic [7:0] OFF_KNEE2  = 8'h10;
	localparam logic [7:0] OFF_LUT_AD = 8'h14;
	localparam logic [7:0] OFF_LUT_DT = 8'h18;
	localparam logic [7:0] OFF_APP_RG = 8'h1c;
	localparam logic [7:0] OFF_APP_B  = 8'h20;
	// control field positions
	localparam int CF_GAM_EN = 0;
	localparam int CF_GAM_SEL = 1;
	localparam int CF_BG_EN = 4;
	localparam int CF_BG_SEL = 5;
	localparam int CF_BG_W = 8;
	localparam int CF_LUT_SEL = 10;
	localparam int CF_LUT_EN = 12;
	localparam int CF_ENH = 13;
	localparam int CF_WB = 16;
	localparam int CF_SPD = 20;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0010_0000;
	localparam logic [31:0] KNEE1_RST = 32'h0800_0800;
	localparam logic [31:0] KNEE2_RST = 32'h0fff_0fff;
	localparam logic [11:0] PIX_MAX = 12'hfff;
	localparam logic [11:0] WB_UNITY = 12'h400;
	localparam logic [35:0] WB_PRESET [6] = '{36'h300_400_600, 36'h4c0_400_480, 0, 0, 0, 0};
	// lookup tables: 17 points per table, spaced 256 counts apart
	localparam int LUT_PTS = 17;
	localparam int LUT_N = 4 * LUT_PTS;
	localparam logic [11:0] LUT_G045 [17] = '{12'h000, 12'h498, 12'h647, 12'h788, 12'h893, 12'h97a,
		12'ha4a, 12'hb07, 12'hbb6, 12'hc59, 12'hcf3, 12'hd84, 12'he0e, 12'he92, 12'hf10, 12'hf8a, 12'hfff};
	// curve depth in 1/256: 1.3, 1.6, 1.9, 2.2, then 1/2.2, 1/1.9, 1/1.6, 1/1.3
	localparam logic [8:0] GAM_K [8] = '{9'h061, 9'h0ae, 9'h0ee, 9'h100, 9'h0eb, 9'h0c7, 9'h097, 9'h059};
	localparam logic [7:0] BG_W [4] = '{8'h1a, 8'h33, 8'h4d, 8'h4d};
	localparam logic [3:0] DIV_TOP = 4'hc;
	localparam int STAGES = 4;

	typedef enum logic [2:0] {WB_OFF = 3'h0, WB_ONCE = 3'h1, WB_AUTO = 3'h2, WB_MANUAL = 3'h3,
		WB_INDOOR = 3'h4, WB_OUTDOOR = 3'h5} ptwb_wb_mode_e;
	typedef enum logic [1:0] {ENH_OFF = 2'h0, ENH_ONE = 2'h1, ENH_TWO = 2'h2} ptwb_enh_mode_e;
	typedef enum logic [1:0] {DV_IDLE = 2'b00, DV_RED = 2'b01, DV_BLUE = 2'b11, DV_UPD = 2'b10} ptwb_div_e;

	// reset contents of table t, point i
	function automatic logic [11:0] lut_default(input int t, input int i);
		int v;
		v = i * 256;
		case (t)
			0: lut_default = LUT_G045[i];
			1: lut_default = 12'(4095 - ((v > 4095) ? 4095 : v));
			2: lut_default = 12'((2 * v > 4095) ? 4095 : 2 * v);
			default: lut_default = 12'((v > 4095) ? 4095 : v);
		endcase
	endfunction
endpackage

/* File: hw/ptwb_top.sv */
// Purpose: tone curves, lookup tables, knee enhancement and white balance on an RGB pixel stream
// Assumes: one pixel per clock, at least 32 idle cycles between frames
// Notes: settings are shadowed while no frame is in the pipeline
//
// The address map and the AXI4-Lite slave port were decided locally.
module ptwb_top
	import ptwb_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int SUM_W = 36
)(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// pixels from sensor readout
	input  wire logic              in_valid,
	input  wire logic              in_sof,
	input  wire logic              in_eof,
	input  wire logic [11:0]       in_r,
	input  wire logic [11:0]       in_g,
	input  wire logic [11:0]       in_b,
	// pixels to output formatter
	output logic                   out_valid,
	output logic                   out_sof,
	output logic                   out_eof,
	output logic [11:0]            out_r,
	output logic [11:0]            out_g,
	output logic [11:0]            out_b
);
	logic [31:0]       ctrl_reg, man_rg_reg, man_b_reg, knee1_reg, knee2_reg;
	logic [31:0]       sh_ctrl_reg, sh_k1_reg, sh_k2_reg;
	logic [11:0]       gain_reg [3];
	logic [11:0]       comp_r_reg, comp_b_reg, tr_reg;
	logic [1:0]        lut_t_reg;
	logic [4:0]        lut_i_reg;
	logic [11:0]       lut_mem [LUT_N];
	logic              in_frame_reg, once_done_reg;
	logic [STAGES-1:0] v_reg, sof_reg, eof_reg;
	logic [11:0]       s1 [3];
	logic [11:0]       s2 [3];
	logic [11:0]       s3 [3];
	logic [11:0]       s4 [3];
	logic [11:0]       pin [3];
	logic [19:0]       sl_reg [3];
	logic [SUM_W-1:0]  sum_reg [3];
	logic [SUM_W-1:0]  sum_next [3];
	logic [SUM_W-1:0]  gsum_reg, bsum_reg, den_reg;
	logic [47:0]       rem_reg, trial;
	logic [12:0]       q_reg, q_next;
	logic [3:0]        cnt_reg;
	ptwb_div_e         dv_reg;
	logic              busy, wr_go, wr_ok, rd_ok, frame_end, lut_wr;
	logic [ADDR_W-1:0] aw_reg, ar_addr;
	logic [31:0]       w_reg, wmask, rd_val;
	logic [11:0]       div_res, k2x, k2y, nx, ny;
	logic [2:0]        spd;
	ptwb_wb_mode_e     sh_wb, live_wb;
	ptwb_enh_mode_e    sh_enh;

	assign pin[0] = in_r;
	assign pin[1] = in_g;
	assign pin[2] = in_b;
	assign sh_wb = ptwb_wb_mode_e'(sh_ctrl_reg[CF_WB +: 3]);
	assign live_wb = ptwb_wb_mode_e'(ctrl_reg[CF_WB +: 3]);
	assign sh_enh = ptwb_enh_mode_e'(sh_ctrl_reg[CF_ENH +: 2]);
	assign busy = in_frame_reg | (|v_reg) | (in_valid & in_sof);
	assign frame_end = in_valid & in_eof;

	// saturate to a 12-bit pixel
	function automatic logic [11:0] sat12(input logic [24:0] v);
		sat12 = (v > 25'(PIX_MAX)) ? PIX_MAX : v[11:0];
	endfunction

	// base gamma curve: x -/+ k*x*(1-x)
	function automatic logic [11:0] gam_f(input logic [11:0] x, input logic [2:0] sel);
		logic [23:0] p;
		logic [20:0] d;
		p = 24'(x) * 24'(PIX_MAX - x);
		d = 21'(p[23:12]) * 21'(GAM_K[sel]);
		gam_f = sel[2] ? sat12(25'(x) + 25'(d[20:8])) : x - 12'(d[20:8]);
	endfunction

	// black gamma bends only the lower half, scaled by weight
	function automatic logic [11:0] bgam_f(input logic [11:0] x, input logic [2:0] sel, input logic [7:0] w);
		logic [23:0] p;
		logic [20:0] d1;
		logic [20:0] d;
		p = 24'(x) * 24'(12'h800 - x);
		d1 = 21'(p[22:11]) * 21'(GAM_K[sel]);
		d = 21'(d1[20:8]) * 21'(w);
		if (x[11])
			bgam_f = x;
		else
			bgam_f = sel[2] ? sat12(25'(x) + 25'(d[20:8])) : x - 12'(d[20:8]);
	endfunction

	// piecewise-linear knee transfer with 12.8 slopes
	function automatic logic [11:0] enh_f(input logic [11:0] x);
		logic [31:0] p;
		logic [11:0] base;
		if (x < sh_k1_reg[11:0])
		begin
			p = 32'(x) * 32'(sl_reg[0]);
			base = 12'h000;
		end
		else if (x < k2x)
		begin
			p = 32'(x - sh_k1_reg[11:0]) * 32'(sl_reg[1]);
			base = sh_k1_reg[27:16];
		end
		else
		begin
			p = 32'(x - k2x) * 32'(sl_reg[2]);
			base = k2y;
		end
		enh_f = sat12(25'(base) + 25'(p[31:8]));
	endfunction

	// slope of one segment, flat where it would fall or has no width
	function automatic logic [19:0] slope_f(input logic [11:0] x0, input logic [11:0] y0,
		input logic [11:0] x1, input logic [11:0] y1);
		if (x1 <= x0 || y1 <= y0)
			slope_f = 20'h00000;
		else
			slope_f = 20'({y1 - y0, 8'h00} / 20'(x1 - x0));
	endfunction

	// one-point mode runs its upper segment straight to full scale
	assign k2x = (sh_enh == ENH_TWO) ? sh_k2_reg[11:0] : PIX_MAX;
	assign k2y = (sh_enh == ENH_TWO) ? sh_k2_reg[27:16] : PIX_MAX;

	// segment slopes follow the frame's shadowed knees
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sl_reg[0] <= 20'h00100;
			sl_reg[1] <= 20'h00100;
			sl_reg[2] <= 20'h00100;
		end
		else
		begin
			sl_reg[0] <= slope_f(12'h000, 12'h000, sh_k1_reg[11:0], sh_k1_reg[27:16]);
			sl_reg[1] <= slope_f(sh_k1_reg[11:0], sh_k1_reg[27:16], k2x, k2y);
			sl_reg[2] <= slope_f(k2x, k2y, PIX_MAX, PIX_MAX);
		end
	end

	// four-stage pixel pipeline, one pixel per clock per stage
	generate
		for (genvar c = 0; c < 3; c++)
		begin : g_chan
			logic [23:0] wb_p;
			logic [11:0] la, lb;
			logic [20:0] lp;
			logic [6:0]  li;
			assign wb_p = 24'(pin[c]) * 24'(gain_reg[c]);
			assign li = 7'(sh_ctrl_reg[CF_LUT_SEL +: 2]) * 7'(LUT_PTS) + 7'(s1[c][11:8]);
			assign la = lut_mem[li];
			assign lb = lut_mem[li + 7'h01];
			assign lp = 21'(signed'({1'b0, lb}) - signed'({1'b0, la})) * 21'(s1[c][7:0]);
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					s1[c] <= 12'h000;
					s2[c] <= 12'h000;
					s3[c] <= 12'h000;
					s4[c] <= 12'h000;
				end
				else
				begin
					s1[c] <= sat12(25'(wb_p[23:10]));
					if (sh_ctrl_reg[CF_LUT_EN])
						s2[c] <= 12'(13'(la) + 13'(signed'(lp[20:8])));
					else if (sh_ctrl_reg[CF_GAM_EN])
						s2[c] <= gam_f(s1[c], sh_ctrl_reg[CF_GAM_SEL +: 3]);
					else
						s2[c] <= s1[c];
					if (sh_ctrl_reg[CF_BG_EN])
						s3[c] <= bgam_f(s2[c], sh_ctrl_reg[CF_BG_SEL +: 3], BG_W[sh_ctrl_reg[CF_BG_W +: 2]]);
					else
						s3[c] <= s2[c];
					s4[c] <= (sh_enh == ENH_OFF) ? s3[c] : enh_f(s3[c]);
				end
			end
		end
	endgenerate

	// frame markers travel beside the pixels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			v_reg <= '0;
			sof_reg <= '0;
			eof_reg <= '0;
			in_frame_reg <= 1'b0;
		end
		else
		begin
			v_reg <= {v_reg[STAGES-2:0], in_valid};
			sof_reg <= {sof_reg[STAGES-2:0], in_valid & in_sof};
			eof_reg <= {eof_reg[STAGES-2:0], frame_end};
			if (in_valid & in_sof & ~in_eof)
				in_frame_reg <= 1'b1;
			else if (frame_end)
				in_frame_reg <= 1'b0;
		end
	end

	assign out_valid = v_reg[STAGES-1];
	assign out_sof = sof_reg[STAGES-1];
	assign out_eof = eof_reg[STAGES-1];
	assign out_r = s4[0];
	assign out_g = s4[1];
	assign out_b = s4[2];

	// shadow settings and gains load only while no frame is in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sh_ctrl_reg <= CTRL_RST;
			sh_k1_reg <= KNEE1_RST;
			sh_k2_reg <= KNEE2_RST;
			gain_reg[0] <= WB_UNITY;
			gain_reg[1] <= WB_UNITY;
			gain_reg[2] <= WB_UNITY;
		end
		else if (!busy)
		begin
			sh_ctrl_reg <= ctrl_reg;
			sh_k1_reg <= knee1_reg;
			sh_k2_reg <= knee2_reg;
			case (live_wb)
				WB_ONCE, WB_AUTO:
				begin
					gain_reg[0] <= comp_r_reg;
					gain_reg[1] <= WB_UNITY;
					gain_reg[2] <= comp_b_reg;
				end
				WB_MANUAL:
				begin
					gain_reg[0] <= man_rg_reg[11:0];
					gain_reg[1] <= man_rg_reg[27:16];
					gain_reg[2] <= man_b_reg[11:0];
				end
				WB_INDOOR, WB_OUTDOOR:
				begin
					gain_reg[0] <= WB_PRESET[3'(live_wb) - 3'h4][35:24];
					gain_reg[1] <= WB_PRESET[3'(live_wb) - 3'h4][23:12];
					gain_reg[2] <= WB_PRESET[3'(live_wb) - 3'h4][11:0];
				end
				default:
				begin
					gain_reg[0] <= WB_UNITY;
					gain_reg[1] <= WB_UNITY;
					gain_reg[2] <= WB_UNITY;
				end
			endcase
		end
	end

	// whole-frame colour sums for the balance estimate
	generate
		for (genvar c = 0; c < 3; c++)
		begin : g_sum
			assign sum_next[c] = (in_sof ? '0 : sum_reg[c]) + SUM_W'(pin[c]);
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					sum_reg[c] <= '0;
				else if (in_valid)
					sum_reg[c] <= sum_next[c];
			end
		end
	endgenerate

	// serial divide green/red then green/blue, unity at 1024
	assign trial = 48'(den_reg) << cnt_reg;
	assign q_next = (rem_reg >= trial) ? (q_reg | (13'h0001 << cnt_reg)) : q_reg;
	assign div_res = q_next[12] ? PIX_MAX : q_next[11:0];
	assign spd = (ctrl_reg[CF_SPD +: 3] == 3'h0 || ctrl_reg[CF_SPD +: 3] > 3'h5) ? 3'h1 : ctrl_reg[CF_SPD +: 3];

	// step toward the target by speed/8 of the error
	function automatic logic [11:0] track(input logic [11:0] cur, input logic [11:0] tgt, input logic [2:0] s);
		logic signed [16:0] e;
		e = 17'(signed'({1'b0, tgt}) - signed'({1'b0, cur})) * 17'(s);
		track = 12'(signed'({1'b0, cur}) + (e >>> 3));
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dv_reg <= DV_IDLE;
			comp_r_reg <= WB_UNITY;
			comp_b_reg <= WB_UNITY;
			tr_reg <= WB_UNITY;
			once_done_reg <= 1'b0;
			rem_reg <= '0;
			den_reg <= '0;
			gsum_reg <= '0;
			bsum_reg <= '0;
			q_reg <= '0;
			cnt_reg <= DIV_TOP;
		end
		else
		begin
			if (sh_wb != WB_ONCE)
				once_done_reg <= 1'b0;
			case (dv_reg)
				DV_IDLE:
					if (frame_end && (sh_wb == WB_AUTO || (sh_wb == WB_ONCE && !once_done_reg)))
					begin
						dv_reg <= DV_RED;
						gsum_reg <= sum_next[1];
						bsum_reg <= sum_next[2];
						den_reg <= sum_next[0];
						rem_reg <= 48'({sum_next[1], 10'h000});
						q_reg <= '0;
						cnt_reg <= DIV_TOP;
					end
				DV_RED, DV_BLUE:
				begin
					if (rem_reg >= trial)
						rem_reg <= rem_reg - trial;
					q_reg <= q_next;
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h0)
					begin
						q_reg <= '0;
						cnt_reg <= DIV_TOP;
						if (dv_reg == DV_RED)
						begin
							tr_reg <= div_res;
							den_reg <= bsum_reg;
							rem_reg <= 48'({gsum_reg, 10'h000});
							dv_reg <= DV_BLUE;
						end
						else
						begin
							comp_b_reg <= (sh_wb == WB_ONCE) ? div_res : track(comp_b_reg, div_res, spd);
							dv_reg <= DV_UPD;
						end
					end
				end
				default:
				begin
					if (sh_wb == WB_ONCE)
					begin
						comp_r_reg <= tr_reg;
						once_done_reg <= 1'b1;
					end
					else
						comp_r_reg <= track(comp_r_reg, tr_reg, spd);
					dv_reg <= DV_IDLE;
				end
			endcase
		end
	end

	// table points: reset contents, host writes one point at a time
	assign lut_wr = wr_go && aw_reg == OFF_LUT_DT;
	generate
		for (genvar e = 0; e < LUT_N; e++)
		begin : g_lut
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					lut_mem[e] <= lut_default(e / LUT_PTS, e % LUT_PTS);
				else if (lut_wr && 7'(lut_t_reg) * 7'(LUT_PTS) + 7'(lut_i_reg) == 7'(e))
					lut_mem[e] <= w_reg[11:0];
			end
		end
	endgenerate

	// write address decode
	assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	always_comb
	begin
		if (aw_reg == OFF_CTRL || aw_reg == OFF_MAN_RG || aw_reg == OFF_MAN_B)
			wr_ok = 1'b1;
		else if (aw_reg == OFF_KNEE1 || aw_reg == OFF_KNEE2 || aw_reg == OFF_LUT_AD || aw_reg == OFF_LUT_DT)
			wr_ok = 1'b1;
		else
			wr_ok = 1'b0;
	end

	// write channels: address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_reg <= '0;
			w_reg <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_reg <= s_axi_wdata & wmask;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// writable registers; strobe-masked data merges with old contents, except in the table address and table data registers
	logic [31:0] wm_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= CTRL_RST;
			man_rg_reg <= {4'h0, WB_UNITY, 4'h0, WB_UNITY};
			man_b_reg <= {20'h00000, WB_UNITY};
			knee1_reg <= KNEE1_RST;
			knee2_reg <= KNEE2_RST;
			lut_t_reg <= 2'h0;
			lut_i_reg <= 5'h00;
			wm_reg <= '0;
		end
		else
		begin
			if (s_axi_wvalid && s_axi_wready)
				wm_reg <= ~wmask;
			if (wr_go && aw_reg == OFF_CTRL)
				ctrl_reg <= (ctrl_reg & wm_reg) | w_reg;
			if (wr_go && aw_reg == OFF_MAN_RG)
				man_rg_reg <= ((man_rg_reg & wm_reg) | w_reg) & 32'h0fff_0fff;
			if (wr_go && aw_reg == OFF_MAN_B)
				man_b_reg <= ((man_b_reg & wm_reg) | w_reg) & 32'h0000_0fff;
			if (wr_go && aw_reg == OFF_KNEE1)
				knee1_reg <= ((knee1_reg & wm_reg) | w_reg) & 32'h0fff_0fff;
			if (wr_go && aw_reg == OFF_KNEE2)
				knee2_reg <= ((knee2_reg & wm_reg) | w_reg) & 32'h0fff_0fff;
			if (wr_go && aw_reg == OFF_LUT_AD)
			begin
				lut_t_reg <= w_reg[9:8];
				lut_i_reg <= (w_reg[4:0] > 5'h10) ? 5'h10 : w_reg[4:0];
			end
			else if (lut_wr)
				lut_i_reg <= (lut_i_reg == 5'h10) ? 5'h00 : lut_i_reg + 5'h01;
		end
	end

	// read decode
	assign ar_addr = s_axi_araddr;
	always_comb
	begin
		rd_ok = 1'b1;
		if (ar_addr == OFF_CTRL)
			rd_val = ctrl_reg;
		else if (ar_addr == OFF_MAN_RG)
			rd_val = man_rg_reg;
		else if (ar_addr == OFF_MAN_B)
			rd_val = man_b_reg;
		else if (ar_addr == OFF_KNEE1)
			rd_val = knee1_reg;
		else if (ar_addr == OFF_KNEE2)
			rd_val = knee2_reg;
		else if (ar_addr == OFF_LUT_AD)
			rd_val = {22'h000000, lut_t_reg, 3'h0, lut_i_reg};
		else if (ar_addr == OFF_LUT_DT)
			rd_val = {20'h00000, lut_mem[7'(lut_t_reg) * 7'(LUT_PTS) + 7'(lut_i_reg)]};
		else if (ar_addr == OFF_APP_RG)
			rd_val = {4'h0, gain_reg[1], 4'h0, gain_reg[0]};
		else if (ar_addr == OFF_APP_B)
			rd_val = {15'h0000, once_done_reg, 4'h0, gain_reg[2]};
		else
		begin
			rd_val = 32'h0000_0000;
			rd_ok = 1'b0;
		end
	end

	// read channel: data one cycle after address accepted
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

/* File: sim/ptwb_top_asserts.sv */
// Purpose: port checks of the tone stage
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every ptwb_top instance
module ptwb_top_asserts
	import ptwb_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pixel stream
	input wire logic        in_valid,
	input wire logic        in_sof,
	input wire logic        in_eof,
	input wire logic        out_valid,
	input wire logic        out_sof,
	input wire logic        out_eof
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// stream timing
	a_pix_latency: assert property (in_valid |-> ##4 out_valid)
		else $error("valid delay");
	a_pix_gap: assert property (!in_valid |-> ##4 !out_valid)
		else $error("spurious pixel");
	a_sof_latency: assert property (in_valid && in_sof |-> ##4 (out_valid && out_sof))
		else $error("sof delay");
	a_eof_latency: assert property (in_valid && in_eof |-> ##4 (out_valid && out_eof))
		else $error("eof delay");
	// register bus answers
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer timing");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bvalid dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer timing");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rvalid dropped");
	a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken early");

	// main scenarios
	c_frame: cover property (in_valid && in_sof);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind ptwb_top ptwb_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .in_valid, .in_sof, .in_eof, .out_valid, .out_sof, .out_eof);

/* File: sim/ptwb_pixel_link.sv */
// Purpose: pixel source and sink around the stage
// Assumes: uniform four-pixel frames, 40 idle cycles after each
// Notes: idle data lines toggle
module ptwb_pixel_link
(
	// clock
	input wire logic         aclk,
	// stream into the stage
	output logic             in_valid,
	output logic             in_sof,
	output logic             in_eof,
	output logic [11:0]      in_r,
	output logic [11:0]      in_g,
	output logic [11:0]      in_b,
	// stream out of the stage
	input wire logic         out_valid,
	input wire logic [11:0]  out_r,
	input wire logic [11:0]  out_g,
	input wire logic [11:0]  out_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] cap_r, cap_g, cap_b;

	// quiet line at time zero
	initial
	begin
		{in_valid, in_sof, in_eof, in_r, in_g, in_b} = '0;
	end

	// last pixel seen
	always @(posedge aclk)
		if (out_valid)
			{cap_r, cap_g, cap_b} <= {out_r, out_g, out_b};

	// one frame, then a 40-cycle gap
	task automatic frame(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge aclk);
			{in_valid, in_sof, in_eof} <= {1'b1, i == 0, i == 3};
			{in_r, in_g, in_b} <= {r, g, b};
		end
		repeat (40)
		begin
			@(posedge aclk);
			{in_valid, in_sof, in_eof} <= 3'b000;
			{in_r, in_g, in_b} <= ~{in_r, in_g, in_b};
		end
	endtask
endmodule

/* File: sim/ptwb_top_test.sv */
// Purpose: self-checking bench of the tone stage
// Assumes: frames come from the link model
// Notes: uniform frames; last pixel stands for all
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module ptwb_top_test import ptwb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r;
	logic [7:0]  aw_a, ar_a;
	logic [31:0] w_d, d;
	logic [1:0]  rs;
	logic [11:0] prev;
	wire logic   aw_rdy, w_rdy, b_v, ar_rdy, r_v, in_valid, in_sof, in_eof, out_valid, out_sof, out_eof;
	wire logic [1:0]  b_resp, r_resp;
	wire logic [31:0] r_d;
	wire logic [11:0] in_r, in_g, in_b, out_r, out_g, out_b;
	int err_count, comparisons, cyc;
	logic [11:0] lut_e [4] = '{LUT_G045[1], 12'heff, 12'h200, 12'h100};

	ptwb_top dut (.aclk, .aresetn, .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .in_valid, .in_sof,
		.in_eof, .in_r, .in_g, .in_b, .out_valid, .out_sof, .out_eof, .out_r, .out_g, .out_b);
	ptwb_pixel_link link (.aclk, .in_valid, .in_sof, .in_eof, .in_r, .in_g, .in_b,
		.out_valid, .out_r, .out_g, .out_b);

	// 40 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			stop_test();
		end
	end

	// write; each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'b00);
		@(posedge aclk);
		{aw_a, w_d} <= {a, v};
		{aw_v, w_v, b_r} <= 3'b111;
		do
		begin
			@(posedge aclk);
			if (aw_rdy) aw_v <= 1'b0;
			if (w_rdy) w_v <= 1'b0;
		end
		while (b_v !== 1'b1);
		b_r <= 1'b0;
		`CHK("bresp", er, b_resp)
	endtask

	// read; data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		ar_a <= a;
		{ar_v, r_r} <= 2'b11;
		do
		begin
			@(posedge aclk);
			if (ar_rdy) ar_v <= 1'b0;
		end
		while (r_v !== 1'b1);
		{v, r} = {r_d, r_resp};
		r_r <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, rs);
		`CHK("register", e, d)
	endtask

	task automatic px(input logic [11:0] r, g, b, er, eg, eb);
		link.frame(r, g, b);
		`CHK("out_r", er, link.cap_r)
		`CHK("out_g", eg, link.cap_g)
		`CHK("out_b", eb, link.cap_b)
	endtask

	task automatic done(input string n);
		$display("test %s done, mismatches so far %0d", n, err_count);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// test sequence
	initial
	begin
		{aresetn, aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, w_d} = '0;
		{err_count, comparisons, cyc} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFF_CTRL, CTRL_RST);
		rchk(OFF_MAN_RG, 32'h0400_0400);
		rchk(OFF_KNEE2, KNEE2_RST);
		rd(8'h24, d, rs);
		`CHK("unmapped", 34'h2_0000_0000, {rs, d})
		wr(OFF_APP_RG, 32'h0, 2'b10);
		done("registers");
		px(12'h123, 12'h456, 12'h789, 12'h123, 12'h456, 12'h789);
		wr(OFF_CTRL, 32'h0013_0000);
		wr(OFF_MAN_RG, 32'h0400_0200);
		wr(OFF_MAN_B, 32'h800);
		px(12'h400, 12'h400, 12'h400, 12'h200, 12'h400, 12'h800);
		rchk(OFF_APP_RG, 32'h0400_0200);
		rchk(OFF_APP_B, 32'h800);
		wr(OFF_MAN_RG, 32'h0400_0000);
		wr(OFF_MAN_B, 32'hfff);
		px(12'h400, 12'h400, 12'hfff, 12'h000, 12'h400, 12'hfff);
		for (int p = 0; p < 2; p++)
		begin
			wr(OFF_CTRL, 32'h0014_0000 + (32'(p) << 16));
			px(12'h400, 12'h400, 12'h400, WB_PRESET[p][35:24], WB_PRESET[p][23:12], WB_PRESET[p][11:0]);
		end
		done("balance");
		wr(OFF_CTRL, 32'h0011_0000);
		link.frame(12'h200, 12'h400, 12'h800);
		rchk(OFF_APP_RG, 32'h0400_0800);
		rchk(OFF_APP_B, 32'h0001_0200);
		px(12'h400, 12'h400, 12'h400, 12'h800, 12'h400, 12'h200);
		rchk(OFF_APP_RG, 32'h0400_0800);
		wr(OFF_CTRL, 32'h0052_0000);
		link.frame(12'h400, 12'h400, 12'h400);
		rchk(OFF_APP_RG, 32'h0400_0580);
		rchk(OFF_APP_B, 32'h340);
		done("once");
		for (int t = 0; t < 4; t++)
		begin
			wr(OFF_CTRL, 32'h0010_1007 | (32'(t) << 10));
			px(12'h100, 12'h100, 12'h100, lut_e[t], lut_e[t], lut_e[t]);
		end
		wr(OFF_LUT_AD, 32'h301);
		wr(OFF_LUT_DT, 32'habc);
		rchk(OFF_LUT_AD, 32'h302);
		wr(OFF_LUT_AD, 32'h301);
		rchk(OFF_LUT_DT, 32'habc);
		px(12'h100, 12'h100, 12'h100, 12'habc, 12'habc, 12'habc);
		done("table");
		for (int s = 0; s < 8; s++)
		begin
			wr(OFF_CTRL, 32'h0010_0001 | (32'(s) << 1));
			link.frame(12'h800, 12'h800, 12'h800);
			`CHK("gamma", (s < 4) ? 2'b01 : 2'b10, {link.cap_r > 12'h800, link.cap_r < 12'h800})
		end
		prev = 12'h400;
		for (int w = 0; w < 3; w++)
		begin
			wr(OFF_CTRL, 32'h0010_0010 | (32'(w) << 8));
			link.frame(12'h400, 12'h400, 12'h400);
			`CHK("black", 1'b1, link.cap_r < prev)
			prev = link.cap_r;
		end
		wr(OFF_CTRL, 32'h0010_0210);
		px(12'hc00, 12'hc00, 12'hc00, 12'hc00, 12'hc00, 12'hc00);
		done("gamma");
		wr(OFF_CTRL, 32'h0010_2000);
		wr(OFF_KNEE1, 32'h0400_0800);
		px(12'h400, 12'h400, 12'h400, 12'h200, 12'h200, 12'h200);
		wr(OFF_CTRL, 32'h0010_4000);
		wr(OFF_KNEE1, 32'h0200_0400);
		wr(OFF_KNEE2, 32'h0e00_0c00);
		px(12'h600, 12'h600, 12'h600, 12'h500, 12'h500, 12'h500);
		done("enhance");
		stop_test();
	end
endmodule
